// *** logic/two_phase_clock_gen.sv ***
// two-phase clock generator with bypassable times-four multiplier
`timescale 1ns/1ps
module two_phase_clock_gen
   import clock_gen_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pins
   input  wire logic oscillator_input,
   input  wire logic clock_multiplier_select,
   // power management from same-clock logic
   input  wire logic cpu_clock_stop,
   input  wire logic periph_clock_stop,
   // phase, clock and multiplier status outputs
   output logic      phase_one_clock,
   output logic      phase_two_clock,
   output logic      system_clock_out,
   output logic      system_clock_pin,
   output logic      cpu_phase_one,
   output logic      cpu_phase_two,
   output logic      periph_phase_one,
   output logic      periph_phase_two,
   output logic      multiplier_active
);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and strap capture
   logic [2:0] osc_sync_reg, osc_sync_next;
   logic [2:0] sel_sync_reg, sel_sync_next;
   logic       osc_level_reg, osc_level_next;
   logic       strap_taken_reg, strap_taken_next;
   logic       mult_reg, mult_next;
   logic [2:0] fill_reg, fill_next;
   logic       osc_valid_reg, osc_valid_next;
   logic       osc_rise;

   always_comb begin
      osc_sync_next    = {osc_sync_reg[1:0], oscillator_input};
      sel_sync_next    = {sel_sync_reg[1:0], clock_multiplier_select};
      osc_level_next   = osc_level_reg;
      strap_taken_next = strap_taken_reg;
      mult_next        = mult_reg;
      fill_next        = {fill_reg[1:0], 1'b1};
      osc_valid_next   = osc_valid_reg;
      // the cleared chain agrees on zero at once, so wait until it holds real pin samples
      // a change counts only once stages two and three agree
      if (fill_reg[2] && osc_sync_reg[1] == osc_sync_reg[2]) begin
         osc_level_next = osc_sync_reg[2];
         osc_valid_next = 1'b1;
      end
      // strap is caught once after reset; later wiggles are ignored
      if (fill_reg[2] && !strap_taken_reg && sel_sync_reg[1] == sel_sync_reg[2]) begin
         strap_taken_next = 1'b1;
         mult_next        = sel_sync_reg[2];
      end
   end

   // the first valid level only loads; a pin already high at reset is no rise
   assign osc_rise = osc_valid_reg && osc_level_next && !osc_level_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         osc_sync_reg    <= 3'h0;
         sel_sync_reg    <= 3'h0;
         osc_level_reg   <= 1'b0;
         strap_taken_reg <= 1'b0;
         mult_reg        <= 1'b0;
         fill_reg        <= 3'h0;
         osc_valid_reg   <= 1'b0;
      end else begin
         fill_reg        <= fill_next;
         osc_valid_reg   <= osc_valid_next;
         osc_sync_reg    <= osc_sync_next;
         sel_sync_reg    <= sel_sync_next;
         osc_level_reg   <= osc_level_next;
         strap_taken_reg <= strap_taken_next;
         mult_reg        <= mult_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // divider-input tick: one per input rise, or four evenly spaced in multiply mode
   // limitation: the input must stay below clk/8; reset to first rise is no period, so the
   // multiplier adds its ticks only from the second rise on
   logic             rise_seen_reg, rise_seen_next;
   logic [CNT_W-1:0] period_cnt_reg, period_cnt_next;
   logic [CNT_W-1:0] period_reg, period_next;
   logic [CNT_W-1:0] sub_cnt_reg, sub_cnt_next;
   logic [1:0]       extra_reg, extra_next;
   logic             f_tick;

   always_comb begin
      period_cnt_next = (period_cnt_reg == CNT_MAX) ? CNT_MAX : period_cnt_reg + CNT_ONE;
      period_next     = period_reg;
      sub_cnt_next    = sub_cnt_reg + CNT_ONE;
      extra_next      = extra_reg;
      rise_seen_next  = rise_seen_reg;
      f_tick          = 1'b0;
      if (osc_rise) begin
         f_tick          = strap_taken_reg;
         rise_seen_next  = 1'b1;
         period_next     = rise_seen_reg ? period_cnt_next : '0;
         period_cnt_next = '0;
         sub_cnt_next    = CNT_ONE;
         extra_next      = (mult_reg && rise_seen_reg) ? EXTRA_TICKS : 2'h0;
      end else if (extra_reg != 2'h0 && sub_cnt_reg >= quarter_of(period_reg)) begin
         f_tick       = 1'b1;
         sub_cnt_next = CNT_ONE;
         extra_next   = extra_reg - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         period_cnt_reg <= '0;
         period_reg     <= '0;
         sub_cnt_reg    <= '0;
         extra_reg      <= 2'h0;
         rise_seen_reg  <= 1'b0;
      end else begin
         rise_seen_reg  <= rise_seen_next;
         period_cnt_reg <= period_cnt_next;
         period_reg     <= period_next;
         sub_cnt_reg    <= sub_cnt_next;
         extra_reg      <= extra_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // halving phase generator; a one-cycle gap keeps the phases apart
   phase_state_e state_reg, state_next;
   logic ph1_next, ph2_next, clk_out_next;
   logic cpu1_next, cpu2_next, per1_next, per2_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET:      if (f_tick) state_next = ST_GAP_TO_ONE;
         ST_ONE:        if (f_tick) state_next = ST_GAP_TO_TWO;
         ST_GAP_TO_TWO: state_next = ST_TWO;
         ST_TWO:        if (f_tick) state_next = ST_GAP_TO_ONE;
         ST_GAP_TO_ONE: state_next = ST_ONE;
         default:       state_next = ST_RESET;
      endcase
      ph1_next     = (state_next == ST_ONE);
      ph2_next     = (state_next == ST_TWO);
      clk_out_next = system_clock_out;
      if (ph1_next && !phase_one_clock) begin
         clk_out_next = 1'b1;
      end else if (ph2_next && !phase_two_clock) begin
         clk_out_next = 1'b0;
      end
      cpu1_next = ph1_next && !cpu_clock_stop;
      cpu2_next = ph2_next && !cpu_clock_stop;
      per1_next = ph1_next && !periph_clock_stop;
      per2_next = ph2_next && !periph_clock_stop;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg         <= ST_RESET;
         phase_one_clock   <= 1'b0;
         phase_two_clock   <= 1'b0;
         system_clock_out  <= 1'b0;
         system_clock_pin  <= 1'b0;
         cpu_phase_one     <= 1'b0;
         cpu_phase_two     <= 1'b0;
         periph_phase_one  <= 1'b0;
         periph_phase_two  <= 1'b0;
         multiplier_active <= 1'b0;
      end else begin
         state_reg         <= state_next;
         phase_one_clock   <= ph1_next;
         phase_two_clock   <= ph2_next;
         system_clock_out  <= clk_out_next;
         system_clock_pin  <= system_clock_out;
         cpu_phase_one     <= cpu1_next;
         cpu_phase_two     <= cpu2_next;
         periph_phase_one  <= per1_next;
         periph_phase_two  <= per2_next;
         multiplier_active <= mult_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions and their helper logic
   logic [1:0] ticks_since_one_reg;
   logic       seen_one_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         ticks_since_one_reg <= 2'h0;
         seen_one_reg        <= 1'b0;
      end else if (ph1_next && !phase_one_clock) begin
         ticks_since_one_reg <= 2'h0;
         seen_one_reg        <= 1'b1;
      end else if (f_tick && ticks_since_one_reg != 2'h3) begin
         ticks_since_one_reg <= ticks_since_one_reg + 2'h1;
      end
   end

   sequence s_one_rise;
      $rose(phase_one_clock);
   endsequence
   sequence s_two_rise;
      $rose(phase_two_clock);
   endsequence

   property p_strap_follows;
      @(posedge clk) disable iff (rst) strap_taken_reg |-> multiplier_active == $past(mult_reg);
   endproperty
   a_strap_follows: assert property (p_strap_follows) else $error("multiplier flag wrong");

   property p_strap_held;
      @(posedge clk) disable iff (rst) (strap_taken_reg && $past(strap_taken_reg)) |-> $stable(mult_reg);
   endproperty
   a_strap_held: assert property (p_strap_held) else $error("strap change after capture");

   property p_bypass_single;
      @(posedge clk) disable iff (rst) (!mult_reg && f_tick) |-> osc_rise;
   endproperty
   a_bypass_single: assert property (p_bypass_single) else $error("tick without input rise");

   property p_mult_quad;
      @(posedge clk) disable iff (rst) (osc_rise && mult_reg) |-> extra_reg == 2'h0;
   endproperty
   a_mult_quad: assert property (p_mult_quad) else $error("multiplier ticks missing");

   property p_no_overlap;
      @(posedge clk) disable iff (rst) !(phase_one_clock && phase_two_clock);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("phases overlap");

   property p_gap_after_one;
      // reset drops phase one too, and is released at an edge, so skip the edge after reset
      @(posedge clk) disable iff (rst) (!$past(rst) && $fell(phase_one_clock))
         |-> !phase_two_clock ##1 phase_two_clock;
   endproperty
   a_gap_after_one: assert property (p_gap_after_one) else $error("phase two not after gap");

   property p_system_clock_out_rise;
      @(posedge clk) disable iff (rst) s_one_rise |-> system_clock_out;
   endproperty
   a_system_clock_out_rise: assert property (p_system_clock_out_rise) else $error("clock out not high on phase one");

   property p_system_clock_out_fall;
      @(posedge clk) disable iff (rst) s_two_rise |-> !system_clock_out;
   endproperty
   a_system_clock_out_fall: assert property (p_system_clock_out_fall) else $error("clock out not low on phase two");

   property p_state_time;
      @(posedge clk) disable iff (rst) (ph1_next && !phase_one_clock && seen_one_reg)
         |-> ticks_since_one_reg == TICKS_PER_STATE;
   endproperty
   a_state_time: assert property (p_state_time) else $error("state time not two ticks");

   property p_cpu_gate;
      @(posedge clk) disable iff (rst) cpu_phase_one |-> phase_one_clock && !$past(cpu_clock_stop);
   endproperty
   a_cpu_gate: assert property (p_cpu_gate) else $error("cpu phase while stopped");

   property p_pin_copy;
      @(posedge clk) disable iff (rst) ##1 system_clock_pin == $past(system_clock_out);
   endproperty
   a_pin_copy: assert property (p_pin_copy) else $error("pin not a copy");

   property p_one_first;
      @(posedge clk) disable iff (rst) (state_reg == ST_RESET) |-> !phase_two_clock ##1 !phase_two_clock;
   endproperty
   a_one_first: assert property (p_one_first) else $error("phase two before phase one");
endmodule : two_phase_clock_gen

// *** logic/clock_gen_pkg.sv ***
// constants and types shared by the two-phase clock generator
package clock_gen_pkg;
   localparam int unsigned CNT_W         = 16;
   localparam logic [1:0]  EXTRA_TICKS   = 2'h3;   // multiplier adds three ticks per input period
   localparam int unsigned QUARTER_SHIFT = 2;      // input period divided by four
   localparam logic [15:0] CNT_ONE       = 16'h0001;
   localparam logic [15:0] CNT_MAX       = 16'hFFFF;
   localparam logic [1:0]  TICKS_PER_STATE = 2'h2; // one state time is two divider-input periods
   localparam real         CLK_PERIOD_NS = 25.0;
   localparam real         STATE_AT_20MHZ_NS = 100.0;
   localparam real         DIV_IN_20MHZ_NS = 50.0;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_ONE,
      ST_GAP_TO_TWO,
      ST_TWO,
      ST_GAP_TO_ONE
   } phase_state_e;

   function automatic logic [CNT_W-1:0] quarter_of(input logic [CNT_W-1:0] period);
      quarter_of = period >> QUARTER_SHIFT;
   endfunction : quarter_of
endpackage : clock_gen_pkg

// *** tb/osc_model.sv ***
// oscillator partner: free-running square wave on the input clock pin
`timescale 1ns/1ps
module osc_model (
   // bench clock
   input  wire logic       clk,
   // half period in bench cycles
   input  wire logic [7:0] half_cycles,
   // pin
   output logic            osc_out
);
   logic [7:0] cnt_reg;

   // a crystal never stops, so the wave runs through reset as well
   initial begin
      osc_out = 1'b0;
      cnt_reg = 8'h00;
   end

   always @(posedge clk) begin
      if (cnt_reg + 8'h01 >= half_cycles) begin
         cnt_reg <= 8'h00;
         osc_out <= ~osc_out;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : osc_model

// *** tb/pll_two_phase_clock_gen_tb_top.sv ***
// self-checking bench for the two-phase clock generator
`timescale 1ns/1ps
module pll_two_phase_clock_gen_tb_top
   import clock_gen_pkg::*;
;
   logic        clk, rst, strap, cstop, pstop, osc, cs_q, ps_q;
   logic        p1, p2, sco, pin, c1, c2, q1, q2, mact, p1_q, p2_q, sco_q, seen;
   logic [7:0]  half;
   logic [31:0] seed;
   int          bad_count, checks_done, cyc, rises, last_rise, prev_rise;

   osc_model u_osc (.clk(clk), .half_cycles(half), .osc_out(osc));

   two_phase_clock_gen DUT (.clk(clk), .rst(rst), .oscillator_input(osc), .clock_multiplier_select(strap),
      .cpu_clock_stop(cstop), .periph_clock_stop(pstop), .phase_one_clock(p1), .phase_two_clock(p2),
      .system_clock_out(sco), .system_clock_pin(pin), .cpu_phase_one(c1), .cpu_phase_two(c2),
      .periph_phase_one(q1), .periph_phase_two(q2), .multiplier_active(mact));

////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   // stop levels as the design saw them at the last edge
   always @(posedge clk) begin
      cs_q <= cstop;
      ps_q <= pstop;
      cyc  <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   // per-cycle model of phase order, clock edges, pin copy and gating
   always @(negedge clk) begin
      if (rst) begin
         rises = 0;
         seen  = 1'b0;
      end else begin
         check("overlap", 32'h0, 32'(p1 & p2));
         check("pin", 32'(sco_q), 32'(pin));
         check("rise", 32'(p1 & ~p1_q), 32'(sco & ~sco_q));
         check("fall", 32'(p2 & ~p2_q), 32'(~sco & sco_q));
         check("cpu", 32'({p1 & ~cs_q, p2 & ~cs_q}), 32'({c1, c2}));
         check("periph", 32'({p1 & ~ps_q, p2 & ~ps_q}), 32'({q1, q2}));
         if (!seen && (p1 | p2)) begin
            seen = 1'b1;
            check("first", 32'h1, 32'(p1));
         end
         if (p1 & ~p1_q) begin
            rises++;
            prev_rise = last_rise;
            last_rise = cyc;
         end
      end
      p1_q  = p1;
      p2_q  = p2;
      sco_q = sco;
   end

////////////////////////////////////////
   // one reset, then twelve input periods with random stops and a late strap flip
   task automatic run_case(input logic mode, input logic [7:0] hc);
      int          p;
      int          exp_r;
      logic [31:0] r;
      p = 2 * int'(hc);
      @(posedge clk);
      strap <= mode;
      half  <= hc;
      rst   <= 1'b1;
      @(posedge clk);
      #1;
      check("reset", 32'h0, 32'({p1, p2, sco, pin, c1, c2, q1, q2, mact}));
      @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 12 * p; i++) begin
         @(posedge clk);
         r = next_rand();
         cstop <= r[0] & r[1];
         pstop <= r[2] & r[3];
         if (i == 4 * p) strap <= ~mode;
      end
      // window edges blur the count, so allow a few phases either way
      exp_r = (mode ? 4 * 11 - 1 : 11) / 2;
      check("rate", 32'h1, 32'(rises >= exp_r - 3 && rises <= exp_r + 3));
      check("strap", 32'(mode), 32'(mact));
      check("state", 32'(mode ? p / 2 : 2 * p), 32'(last_rise - prev_rise));
   endtask : run_case

   initial begin
      seed  = 32'h593f_050a;
      rst   = 1'b1;
      strap = 1'b0;
      cstop = 1'b0;
      pstop = 1'b0;
      half  = 8'h08;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         run_case(1'(k % 2), 8'(8 + 2 * (next_rand() % 13)));
      end
      stop_test();
   end
endmodule : pll_two_phase_clock_gen_tb_top
